// [verilog/uefc_pkg.sv]
// package: offsets, field layout, reset values and carriers of the ep0 function control block
package uefc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // function control fields
  localparam int CTRL_PULLUP_CONNECT  = 7;
  localparam int CTRL_FEN   = 6;
  localparam int CTRL_REMOTE_WAKE_REQUEST  = 5;
  localparam int CTRL_BUS_RESET_AUTORESET_ENABLE = 4;
  localparam int CTRL_BUSY  = 1;
  localparam int CTRL_DIR   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h50;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;
  // event flag fields
  localparam int FLG_BUSRST = 7;
  localparam int FLG_WAKE   = 3;
  localparam int FLG_SETUP  = 2;
  localparam int FLG_EP0    = 1;
  localparam int FLG_OVWR   = 0;
  localparam logic [7:0] FLG_USED  = 8'h8F;
  localparam logic [7:0] FLG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // remote wakeup signalling time
  localparam int CLK_MHZ      = 100;
  localparam int WAKE_TIME_US = 1000;
  localparam int WAKE_CYCLES  = WAKE_TIME_US * CLK_MHZ;
  localparam int WCNT_W       = 17;

  // wakeup sequencer, gray on each step except end back to idle
  typedef enum logic [1:0] {
    W_IDLE  = 2'b00,
    W_DRIVE = 2'b01,
    W_END   = 2'b11
  } uefc_wake_type;

  // events from the upstream port logic, one-cycle pulses
  typedef struct packed {
    logic bus_reset;
    logic setup_token;
    logic in_token;
    logic out_token;
    logic xfer_done;
    logic xfer_zero_len;
  } uefc_link_in_type;

  // answers and levels toward the upstream port logic
  typedef struct packed {
    logic setup_stall;
    logic setup_accept;
    logic ep0_stall;
    logic wake_drive;
    logic module_reset;
    logic pullup_en;
    logic function_en;
  } uefc_link_out_type;
endpackage

// [verilog/uefc_ep0_ctrl.sv]
// ep0 function control: control register, event flags, wakeup and stall decisions
//
// How it works
// - writing one to remote_wake_request starts resume signalling on the bus
// - remote_wake_request clears itself once signalling has ended
// - writing zero to remote_wake_request changes nothing
// - autoreset off: bus reset only raises bus_reset_flag, no module reset
// - autoreset on: bus reset raises flag, resets module, clears other flags
// - module reset from bus reset keeps pullup_connect set
// - writing zero to the busy bit changes nothing
// - busy clears when software clears the control-request flag
// - while busy, every SETUP packet gets a STALL
// - direction zero: an early IN token is stalled
// - direction one: an early OUT token is stalled
// - zero-length handshake completion raises no endpoint event
// - port reset sets bus_reset_flag; module reset leaves it alone
// - clearing the control-request flag frees the buffer for the next request
// - new request before flag clear sets ctrl_request_overwrite_flag
module uefc_ep0_ctrl #(
  parameter int unsigned WAKE_CYCLES = uefc_pkg::WAKE_CYCLES
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire uefc_pkg::uefc_link_in_type  link_in,
  output uefc_pkg::uefc_link_out_type      link_out,
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  // register map, one byte in the low lane of each word:
  //   ctrl    connect, enable, wake request, autoreset, busy, direction
  //   flags   bus reset, wake done, request, ep0 done, overwrite; write one clears
  //   mask    same layout as flags; irq is the or of flags anded with mask
  //   status  wake drive level and sequencer state, read only

  logic [7:0]                 ctrl_q, ctrl_d;
  logic [7:0]                 flags_q, flags_d;
  logic [7:0]                 mask_q;
  logic [7:0]                 rd_mux;
  logic [31:0]                prdata_q;
  logic                       slverr_q;
  uefc_pkg::uefc_wake_type    wst_q, wst_d;
  logic [uefc_pkg::WCNT_W-1:0] wcnt_q, wcnt_d;
  uefc_pkg::uefc_link_out_type lo_q, lo_d;

  wire setup_ph = psel & ~penable;
  wire access   = psel & penable;
  wire wr_en    = access & pwrite & pstrb[0];
  wire hit_ctrl = (paddr == uefc_pkg::OFS_CTRL);
  wire hit_flg  = (paddr == uefc_pkg::OFS_FLAGS);
  wire hit_mask = (paddr == uefc_pkg::OFS_MASK);
  wire hit_stat = (paddr == uefc_pkg::OFS_STATUS);
  wire mapped   = hit_ctrl | hit_flg | hit_mask | hit_stat;
  wire wr_ctrl  = wr_en & hit_ctrl;
  wire wr_flg   = wr_en & hit_flg;
  wire wr_mask  = wr_en & hit_mask;
  wire [7:0] wb = pwdata[7:0];

  // zero wait states; read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q & access;

  // read selection, reserved bits read zero
  wire [7:0] stat_v = {5'h00, lo_q.wake_drive, wst_q};
  assign rd_mux = hit_ctrl ? ctrl_q :
                  hit_flg  ? flags_q :
                  hit_mask ? mask_q :
                  hit_stat ? stat_v : 8'h00;

  // next read word, error flag and mask, each taken at its own edge only
  wire [31:0] prdata_d = {24'h000000, rd_mux};
  wire        slverr_d = ~mapped;
  wire [7:0]  mask_d   = wb & uefc_pkg::FLG_USED;

  ////////////////////////////////////////////////////////////////////////////
  // event qualification

  wire bus_reset_autoreset_enable     = ctrl_q[uefc_pkg::CTRL_BUS_RESET_AUTORESET_ENABLE];
  wire busy      = ctrl_q[uefc_pkg::CTRL_BUSY];
  wire dir_in    = ctrl_q[uefc_pkg::CTRL_DIR];
  wire auto_rst  = link_in.bus_reset & bus_reset_autoreset_enable;
  // a stalled setup never reaches the buffer
  wire setup_stl = link_in.setup_token & busy;
  wire setup_acc = link_in.setup_token & ~busy;
  wire ovwr_ev   = setup_acc & flags_q[uefc_pkg::FLG_SETUP];
  // early handshake in the wrong direction is stalled
  wire ep0_stl   = (link_in.in_token & ~dir_in)
                 | (link_in.out_token & dir_in);
  // zero-length status stage completes silently
  wire ep0_ev    = link_in.xfer_done & ~link_in.xfer_zero_len;
  wire setup_clr = wr_flg & wb[uefc_pkg::FLG_SETUP];
  wire wake_go   = wr_ctrl & wb[uefc_pkg::CTRL_REMOTE_WAKE_REQUEST];
  wire wake_end  = (wst_q == uefc_pkg::W_END);

  ////////////////////////////////////////////////////////////////////////////
  // control register next value

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      // pullup_connect, fen, bus_reset_autoreset_enable, dir are plain; reserved bits never stored
      ctrl_d[uefc_pkg::CTRL_PULLUP_CONNECT]  = wb[uefc_pkg::CTRL_PULLUP_CONNECT];
      ctrl_d[uefc_pkg::CTRL_FEN]   = wb[uefc_pkg::CTRL_FEN];
      ctrl_d[uefc_pkg::CTRL_BUS_RESET_AUTORESET_ENABLE] = wb[uefc_pkg::CTRL_BUS_RESET_AUTORESET_ENABLE];
      ctrl_d[uefc_pkg::CTRL_DIR]   = wb[uefc_pkg::CTRL_DIR];
      // set-only bits: a zero write leaves them
      if (wb[uefc_pkg::CTRL_BUSY]) begin
        ctrl_d[uefc_pkg::CTRL_BUSY] = 1'b1;
      end
      if (wb[uefc_pkg::CTRL_REMOTE_WAKE_REQUEST]) begin
        ctrl_d[uefc_pkg::CTRL_REMOTE_WAKE_REQUEST] = 1'b1;
      end
    end
    // clearing the setup flag frees the request buffer
    if (setup_clr) begin
      ctrl_d[uefc_pkg::CTRL_BUSY] = 1'b0;
    end
    if (wake_end) begin
      ctrl_d[uefc_pkg::CTRL_REMOTE_WAKE_REQUEST] = 1'b0;
    end
    // module reset keeps pullup_connect and the enables, drops transfer state
    if (auto_rst) begin
      ctrl_d[uefc_pkg::CTRL_REMOTE_WAKE_REQUEST] = 1'b0;
      ctrl_d[uefc_pkg::CTRL_BUSY] = 1'b0;
      ctrl_d[uefc_pkg::CTRL_DIR]  = 1'b0;
      ctrl_d[uefc_pkg::CTRL_PULLUP_CONNECT] = ctrl_q[uefc_pkg::CTRL_PULLUP_CONNECT];
    end
    // reserved bits forced to zero whatever software writes
    ctrl_d[3:2] = 2'b00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags: write one clears, a new event wins over the clear

  always_comb begin
    flags_d = flags_q;
    if (wr_flg) begin
      flags_d = flags_q & ~(wb & uefc_pkg::FLG_USED);
    end
    // module reset drops every pending event except bus reset
    if (auto_rst) begin
      flags_d = flags_q & (8'h01 << uefc_pkg::FLG_BUSRST);
    end
    // events come last, so a set beats a clear written in the same cycle
    if (link_in.bus_reset) begin
      flags_d[uefc_pkg::FLG_BUSRST] = 1'b1;
    end
    if (setup_acc) begin
      flags_d[uefc_pkg::FLG_SETUP] = 1'b1;
    end
    if (ovwr_ev) begin
      flags_d[uefc_pkg::FLG_OVWR] = 1'b1;
    end
    if (ep0_ev) begin
      flags_d[uefc_pkg::FLG_EP0] = 1'b1;
    end
    if (wake_end) begin
      flags_d[uefc_pkg::FLG_WAKE] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remote wakeup sequencer

  always_comb begin
    wst_d  = wst_q;
    wcnt_d = wcnt_q;
    // a request while signalling runs is ignored, nothing restarts
    case (wst_q)
      uefc_pkg::W_IDLE: begin
        if (wake_go & ~auto_rst) begin
          wst_d  = uefc_pkg::W_DRIVE;
          wcnt_d = uefc_pkg::WCNT_W'(WAKE_CYCLES - 1);
        end
      end
      uefc_pkg::W_DRIVE: begin
        // aborted by a module reset so the bus is released at once
        if (auto_rst) begin
          wst_d = uefc_pkg::W_IDLE;
        end else if (wcnt_q == '0) begin
          wst_d = uefc_pkg::W_END;
        end else begin
          wcnt_d = wcnt_q - 1'b1;
        end
      end
      uefc_pkg::W_END: begin
        wst_d = uefc_pkg::W_IDLE;
      end
      default: begin
        wst_d = uefc_pkg::W_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // link answers, all registered

  always_comb begin
    lo_d              = '0;
    lo_d.setup_stall  = setup_stl;
    lo_d.setup_accept = setup_acc;
    lo_d.ep0_stall    = ep0_stl;
    lo_d.wake_drive   = (wst_d == uefc_pkg::W_DRIVE);
    lo_d.module_reset = auto_rst;
    // pullup follows the next control value, so it never dips at an autoreset
    lo_d.pullup_en    = ctrl_d[uefc_pkg::CTRL_PULLUP_CONNECT];
    lo_d.function_en  = ctrl_d[uefc_pkg::CTRL_FEN];
  end
  assign link_out = lo_q;

  // one level interrupt from unmasked sticky flags
  assign irq = |(flags_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // state registers, one short block each, all frozen while ce is low

  // control register; reset leaves the function enabled and autoreset on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= uefc_pkg::CTRL_RESET;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // sticky event flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= uefc_pkg::FLG_RESET;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  // mask; unimplemented flag bits can never raise irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= uefc_pkg::MASK_RESET;
    end else if (ce && wr_mask) begin
      mask_q <= mask_d;
    end
  end

  // wakeup sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst_q <= uefc_pkg::W_IDLE;
    end else if (ce) begin
      wst_q <= wst_d;
    end
  end

  // wakeup down counter; only meaningful while driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_q <= '0;
    end else if (ce) begin
      wcnt_q <= wcnt_d;
    end
  end

  // link answers; a frozen cycle stretches pulses, keep ce high around events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_q <= '0;
    end else if (ce) begin
      lo_q <= lo_d;
    end
  end

  // read word caught in the setup phase, steady through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (ce && setup_ph) begin
      prdata_q <= prdata_d;
    end
  end

  // unmapped address flag, shown only during the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_q <= 1'b0;
    end else if (ce && setup_ph) begin
      slverr_q <= slverr_d;
    end
  end

endmodule

// [test/uefc_chk.sv]
// checker: port relations of the ep0 function control block
module uefc_chk #(
  parameter int unsigned WAKE_CYCLES = uefc_pkg::WAKE_CYCLES
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        ce,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire uefc_pkg::uefc_link_in_type  link_in,
  input wire uefc_pkg::uefc_link_out_type link_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        busy_q, dir_q, bus_reset_autoreset_enable_q;
  logic [16:0] wcnt_q;
  // busy and direction are not at the ports, so software writes are tracked here
  wire wr_ctrl = psel && penable && pwrite && pstrb[0] && ce && paddr == uefc_pkg::OFS_CTRL;
  wire wr_flg  = psel && penable && pwrite && pstrb[0] && ce && paddr == uefc_pkg::OFS_FLAGS;
  wire brst    = ce && link_in.bus_reset && bus_reset_autoreset_enable_q;
  // shadow state; reset value leaves only autoreset set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy_q, dir_q, bus_reset_autoreset_enable_q, wcnt_q} <= 20'h20000;
    end else begin
      busy_q  <= !brst && !(wr_flg && pwdata[2]) && (busy_q || (wr_ctrl && pwdata[1]));
      dir_q   <= !brst && (wr_ctrl ? pwdata[0] : dir_q);
      bus_reset_autoreset_enable_q <= wr_ctrl ? pwdata[4] : bus_reset_autoreset_enable_q;
      wcnt_q  <= !link_out.wake_drive ? 17'h0 : ce ? wcnt_q + 17'h1 : wcnt_q;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a request only counts while the wake sequencer is quiet
  sequence s_wake_go;
    wr_ctrl && pwdata[5] && !brst && !link_out.wake_drive && !$past(link_out.wake_drive);
  endsequence
  property p_wake_go; s_wake_go |=> link_out.wake_drive; endproperty
  a_wake_go: assert property (p_wake_go) else $error("wakeup not started");
  property p_wake_len; $fell(link_out.wake_drive) && !link_out.module_reset |-> wcnt_q == WAKE_CYCLES; endproperty
  a_wake_len: assert property (p_wake_len) else $error("wakeup length wrong");
  property p_setup_stall; link_in.setup_token && ce && busy_q |=> link_out.setup_stall; endproperty
  a_setup_stall: assert property (p_setup_stall) else $error("setup not stalled");
  property p_setup_ok; link_in.setup_token && ce && !busy_q |=> link_out.setup_accept && !link_out.setup_stall; endproperty
  a_setup_ok: assert property (p_setup_ok) else $error("setup refused");
  property p_in_stall; link_in.in_token && ce && !dir_q |=> link_out.ep0_stall; endproperty
  a_in_stall: assert property (p_in_stall) else $error("early in not stalled");
  property p_out_stall; link_in.out_token && ce && dir_q |=> link_out.ep0_stall; endproperty
  a_out_stall: assert property (p_out_stall) else $error("early out not stalled");
  property p_rst_cause; link_out.module_reset |-> $past(brst); endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("module reset uncaused");
  property p_pullup; link_out.module_reset |-> $stable(link_out.pullup_en); endproperty
  a_pullup: assert property (p_pullup) else $error("pullup lost on reset");
endmodule

// [test/uefc_host.sv]
// host model: one-cycle token and reset pulses on the upstream link
module uefc_host (
  input  wire logic                  pclk,
  output uefc_pkg::uefc_link_in_type link_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial link_in = '0;
  // each event lasts exactly one cycle, as the port logic makes it
  task automatic send(input logic [5:0] ev);
    @(posedge pclk);
    link_in <= ev;
    @(posedge pclk);
    link_in <= '0;
  endtask
endmodule

// [test/tb.sv]
// testbench: apb software and host pulses against expected register values
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WAKE = 8;
  localparam logic [7:0] CT = uefc_pkg::OFS_CTRL;
  localparam logic [7:0] FL = uefc_pkg::OFS_FLAGS;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, irq, err_q;
  logic        ce = 1'b1;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  paddr = 8'h00, c, d;
  logic [31:0] pwdata = 32'h0, prdata, r;
  int          err_total = 0, n_compared = 0, seed = 1;
  uefc_pkg::uefc_link_in_type  link_in;
  uefc_pkg::uefc_link_out_type link_out;
  uefc_ep0_ctrl #(.WAKE_CYCLES(WAKE)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .link_in(link_in),
    .link_out(link_out), .irq(irq));
  uefc_host i_host (.pclk(pclk), .link_in(link_in));
  always #5 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  // one transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, r);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, well beyond the some 160 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", CT, uefc_pkg::CTRL_RESET);
    rd("mask", uefc_pkg::OFS_MASK, 8'h00);
    c = uefc_pkg::CTRL_RESET;
    // random control writes; a zero never clears busy
    repeat (6) begin
      d = 8'($random(seed)) & 8'hD3;
      apb(1'b1, CT, d);
      c = (d & 8'hD1) | ((c | d) & 8'h02);
      rd("ctrl", CT, c);
    end
    apb(1'b1, CT, 8'h52);
    i_host.send(6'h10);
    #1 chk("setup stall", 1, link_out.setup_stall);
    apb(1'b1, FL, 8'h04);
    rd("ctrl", CT, 8'h50);
    i_host.send(6'h10);
    i_host.send(6'h10);
    #1 chk("setup accept", 1, link_out.setup_accept);
    rd("flags", FL, 8'h05);
    apb(1'b1, uefc_pkg::OFS_MASK, 8'h01);
    #1 chk("irq on", 1, irq);
    apb(1'b1, FL, 8'h05);
    #1 chk("irq off", 0, irq);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, CT, 8'h50 | 8'(i));
      i_host.send(6'h08);
      #1 chk("in stall", i == 0, link_out.ep0_stall);
      i_host.send(6'h04);
      #1 chk("out stall", i == 1, link_out.ep0_stall);
    end
    i_host.send(6'h03);
    rd("flags", FL, 8'h00);
    i_host.send(6'h02);
    rd("flags", FL, 8'h02);
    apb(1'b1, CT, 8'h50);
    #1 chk("no wake", 0, link_out.wake_drive);
    apb(1'b1, CT, 8'hF0);
    #1 chk("wake", 1, link_out.wake_drive);
    rd("status", uefc_pkg::OFS_STATUS, 8'h05);
    repeat (WAKE + 2) @(posedge pclk);
    rd("ctrl", CT, 8'hD0);
    rd("flags", FL, 8'h0A);
    apb(1'b1, CT, 8'hC3);
    i_host.send(6'h20);
    #1 chk("no modrst", 0, link_out.module_reset);
    rd("ctrl", CT, 8'hC3);
    rd("flags", FL, 8'h8A);
    apb(1'b1, CT, 8'hD3);
    i_host.send(6'h20);
    #1 chk("modrst", 1, link_out.module_reset);
    chk("pullup", 1, link_out.pullup_en);
    chk("fen", 1, link_out.function_en);
    rd("ctrl", CT, 8'hD0);
    rd("flags", FL, 8'h80);
    // a frozen clock enable and a low byte strobe both leave ctrl alone
    ce <= 1'b0;
    apb(1'b1, CT, 8'h13);
    ce <= 1'b1;
    rd("ctrl frozen", CT, 8'hD0);
    pstrb <= 4'hE;
    apb(1'b1, CT, 8'h13);
    pstrb <= 4'hF;
    rd("ctrl no strobe", CT, 8'hD0);
    rd("unmapped", 8'h10, 8'h00);
    chk("slverr", 1, err_q);
    conclude();
  end
endmodule
bind uefc_ep0_ctrl uefc_chk #(.WAKE_CYCLES(WAKE_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .link_in(link_in), .link_out(link_out));
